/* File: ust_status.sv */
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
module ust_status (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // register port
   input wire logic [ust_pkg::UST_ADDR_W-1:0] addr_i,
   input wire logic [ust_pkg::UST_DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [ust_pkg::UST_DATA_W-1:0] rdata_o,
   // received characters from the deserializer
   input wire logic rx_char_valid_i,
   input wire logic [7:0] rx_char_i,
   input wire logic rx_par_err_i,
   input wire logic rx_frm_err_i,
   // serial line and handshake
   input wire logic cts_n_i,
   output logic txd_o,
   // interrupt
   output logic irq_o
);
   import ust_pkg::*;

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   ust_state_t st_reg; // block state outside the fifos
   ust_state_t st_next; // its next value
   logic tx_in_ready; // tx fifo has space
   logic tx_out_valid; // tx fifo holds a byte
   logic tx_out_ready; // serializer takes a byte
   logic [7:0] tx_head; // oldest tx byte
   logic rx_in_ready; // rx fifo has space
   logic rx_out_valid; // rx fifo holds a byte
   logic [7:0] rx_head; // oldest rx byte
   logic wr_data; // software write to data port
   logic rd_data; // software read of data port
   logic rx_push; // character enters rx fifo
   logic [UST_EV_W-1:0] events; // one-cycle event pulses

   // ----------------------------------------
   // address decode helper
   // ----------------------------------------
   function automatic logic hit(input logic [UST_ADDR_W-1:0] a,
                                input logic [15:0] off);
      hit = (a == off);
   endfunction

   // strobes on the data port
   assign wr_data = wr_i && hit(addr_i, UST_OFF_DATA);
   assign rd_data = rd_i && hit(addr_i, UST_OFF_DATA);
   assign rx_push = rx_char_valid_i && rx_in_ready;
   // a byte leaves the queue only at a character boundary with cts on
   assign tx_out_ready = (st_reg.state == UST_TX_IDLE) && st_reg.cts;

   // ----------------------------------------
   // fifos
   // ----------------------------------------
   // transmit queue, filled by data port writes
   ust_fifo u_tx_fifo (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .in_valid_i(wr_data),
      .in_ready_o(tx_in_ready),
      .in_data_i(wdata_i[7:0]),
      .out_valid_o(tx_out_valid),
      .out_ready_i(tx_out_ready),
      .out_data_o(tx_head)
   );
   // receive queue, drained by data port reads
   ust_fifo u_rx_fifo (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .in_valid_i(rx_char_valid_i),
      .in_ready_o(rx_in_ready),
      .in_data_i(rx_char_i),
      .out_valid_o(rx_out_valid),
      .out_ready_i(rd_data),
      .out_data_o(rx_head)
   );

   // ----------------------------------------
   // event pulses for the interrupt logic
   // ----------------------------------------
   always_comb begin
      events = '0;
      events[UST_EV_RX_CHAR] = rx_push;
      events[UST_EV_PAR] = rx_push && rx_par_err_i;
      events[UST_EV_FRM] = rx_push && rx_frm_err_i;
      events[UST_EV_OVR] = rx_char_valid_i && !rx_in_ready;
      events[UST_EV_TX_IDLE] = st_next.tx_idle && !st_reg.tx_idle;
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      logic [9:0] sh;
      sh = {1'b1, st_reg.shift[9:1]};
      st_next = st_reg;
      st_next.int_stat = st_reg.int_stat;
      // live handshake level, pin is active low
      st_next.cts = !cts_n_i;
      // serializer
      case (st_reg.state)
         UST_TX_IDLE: begin
            // start only when cts was seen asserted
            if (tx_out_valid && st_reg.cts) begin
               st_next.state = UST_TX_SHIFT;
               st_next.shift = {1'b1, tx_head, 1'b0};
               st_next.bits = UST_FRAME_BITS;
               st_next.baud = 8'h00;
               st_next.txd = 1'b0;
            end
         end
         UST_TX_SHIFT: begin
            // the character in flight always completes
            if (st_reg.baud == UST_BIT_CYCLES - 8'h01) begin
               st_next.baud = 8'h00;
               if (st_reg.bits == 4'h0) begin
                  st_next.state = UST_TX_IDLE;
                  st_next.txd = 1'b1;
               end else begin
                  st_next.bits = st_reg.bits - 4'h1;
                  st_next.shift = sh;
                  st_next.txd = sh[0];
               end
            end else begin
               st_next.baud = st_reg.baud + 8'h01;
            end
         end
         default: begin
            st_next.state = UST_TX_IDLE;
         end
      endcase
      // idle when queue empty and nothing shifting
      st_next.tx_idle = !tx_out_valid && (st_next.state == UST_TX_IDLE);
      // error flags: set wins over the read that clears them
      st_next.par_err = (st_reg.par_err && !rd_data) || events[UST_EV_PAR];
      st_next.frm_err = (st_reg.frm_err && !rd_data) || events[UST_EV_FRM];
      st_next.ovr = (st_reg.ovr && !rd_data) || events[UST_EV_OVR];
      // register writes
      if (wr_i) begin
         if (hit(addr_i, UST_OFF_INT_EN)) begin
            st_next.int_en = wdata_i[UST_EV_W-1:0];
         end else if (hit(addr_i, UST_OFF_INT_CLR)) begin
            st_next.int_stat = st_reg.int_stat & ~wdata_i[UST_EV_W-1:0];
         end
      end
      // sticky events, set wins over clear
      st_next.int_stat = st_next.int_stat | events;
      st_next.irq = |(st_next.int_stat & st_next.int_en);
      // read data, valid only in the cycle after the strobe
      st_next.rdata = 16'h0000;
      if (rd_i) begin
         if (hit(addr_i, UST_OFF_STATUS)) begin
            st_next.rdata[UST_BIT_TX_IDLE] = st_reg.tx_idle;
            st_next.rdata[UST_BIT_PAR_ERR] = st_reg.par_err;
            st_next.rdata[UST_BIT_FRM_ERR] = st_reg.frm_err;
            st_next.rdata[UST_BIT_RX_OVR] = st_reg.ovr;
            st_next.rdata[UST_BIT_TX_SPACE] = tx_in_ready;
            st_next.rdata[UST_BIT_RX_VALID] = rx_out_valid;
            st_next.rdata[UST_BIT_CTS] = st_reg.cts;
         end else if (hit(addr_i, UST_OFF_DATA)) begin
            // oldest byte, zero when empty
            st_next.rdata[7:0] = rx_out_valid ? rx_head : 8'h00;
         end else if (hit(addr_i, UST_OFF_INT_STAT)) begin
            st_next.rdata[UST_EV_W-1:0] = st_reg.int_stat;
         end else if (hit(addr_i, UST_OFF_INT_EN)) begin
            st_next.rdata[UST_EV_W-1:0] = st_reg.int_en;
         end else begin
            // clear register and unmapped read zero
            st_next.rdata = 16'h0000;
         end
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_reg <= UST_STATE_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs straight from flops
   assign rdata_o = st_reg.rdata;
   assign txd_o = st_reg.txd;
   assign irq_o = st_reg.irq;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   // empty queue and quiet serializer must show idle on the next edge
   a_idle_flag_track: assert property (
      (!tx_out_valid && st_reg.state == UST_TX_IDLE) |=> st_reg.tx_idle)
      else $error("tx idle flag low while queue empty and serializer idle");
   // a queued byte must drop the idle flag
   a_idle_flag_busy: assert property (
      tx_out_valid |=> !st_reg.tx_idle)
      else $error("tx idle flag high while a byte is queued");
   a_par_set_read: assert property (
      (rx_push && rx_par_err_i) |=> st_reg.par_err)
      else $error("parity error flag not set");
   a_par_clear_read: assert property (
      (rd_data && !events[UST_EV_PAR]) |=> !st_reg.par_err)
      else $error("parity error flag not cleared by data read");
   a_frm_set_read: assert property (
      (rx_push && rx_frm_err_i) |=> st_reg.frm_err ##1 (st_reg.frm_err || $past(rd_data)))
      else $error("framing error flag lost");
   a_ovr_on_full: assert property (
      (rx_char_valid_i && !rx_in_ready) |=> st_reg.ovr)
      else $error("overrun flag not set");
   // sampled reset guard keeps the release edge from comparing a reset value
   a_cts_level: assert property (
      resetn_i |=> st_reg.cts == !$past(cts_n_i))
      else $error("cts bit does not follow pin");
   a_no_start_held: assert property (
      (st_reg.state == UST_TX_IDLE && !st_reg.cts) |=> st_reg.state == UST_TX_IDLE)
      else $error("character started while cts deasserted");
   a_frame_length: assert property (
      (st_reg.state == UST_TX_IDLE && tx_out_valid && st_reg.cts) |=>
         (st_reg.state == UST_TX_SHIFT) [*8])
      else $error("character cut short");
   a_hold_queue: assert property (
      (tx_out_valid && !st_reg.cts && !wr_data && st_reg.state == UST_TX_IDLE) |=>
         tx_out_valid && tx_head == $past(tx_head))
      else $error("held character lost or reordered");
   a_rd_pops_head: assert property (
      (rd_data && rx_out_valid) |=> rdata_o[7:0] == $past(rx_head))
      else $error("data read returned wrong byte");
   a_space_bit: assert property (
      (rd_i && hit(addr_i, UST_OFF_STATUS)) |=>
         rdata_o[UST_BIT_TX_SPACE] == $past(tx_in_ready) &&
         rdata_o[UST_BIT_RX_VALID] == $past(rx_out_valid))
      else $error("space or valid bit wrong");

   c_tx_start: cover property (st_reg.state == UST_TX_IDLE ##1 st_reg.state == UST_TX_SHIFT);
   c_overrun: cover property (events[UST_EV_OVR]);
   c_cts_hold: cover property (tx_out_valid && !st_reg.cts);
   c_irq: cover property (!irq_o ##1 irq_o);
endmodule // ust_status

/* File: ust_pkg.sv */
// Functional notes
// - tx idle bit6, reset one
// - parity error bit5, cleared by data read
// - framing error bit4, cleared by data read
// - overrun bit3 when receive FIFO full
// - bit0 shows live clear-to-send level
// - finish current character, then hold off
// - held characters stay queued in order
// - data read pops rx, write pushes tx
package ust_pkg;
   // ----------------------------------------
   // bus widths and register offsets
   // ----------------------------------------
   localparam int UST_ADDR_W = 16;
   localparam int UST_DATA_W = 16;
   localparam logic [15:0] UST_OFF_STATUS = 16'h44A4; // uart status, read only
   localparam logic [15:0] UST_OFF_DATA = 16'h449E; // data port
   localparam logic [15:0] UST_OFF_INT_STAT = 16'h44C0; // sticky events, read only
   localparam logic [15:0] UST_OFF_INT_EN = 16'h44C2; // event enables
   localparam logic [15:0] UST_OFF_INT_CLR = 16'h44C4; // write one to clear
   // ----------------------------------------
   // status bit positions
   // ----------------------------------------
   localparam int UST_BIT_TX_IDLE = 6;
   localparam int UST_BIT_PAR_ERR = 5;
   localparam int UST_BIT_FRM_ERR = 4;
   localparam int UST_BIT_RX_OVR = 3;
   localparam int UST_BIT_TX_SPACE = 2;
   localparam int UST_BIT_RX_VALID = 1;
   localparam int UST_BIT_CTS = 0;
   // ----------------------------------------
   // interrupt event positions
   // ----------------------------------------
   localparam int UST_EV_W = 5;
   localparam int UST_EV_RX_CHAR = 0;
   localparam int UST_EV_PAR = 1;
   localparam int UST_EV_FRM = 2;
   localparam int UST_EV_OVR = 3;
   localparam int UST_EV_TX_IDLE = 4;
   // ----------------------------------------
   // fifo and timing
   // ----------------------------------------
   localparam int UST_FIFO_DEPTH = 4;
   localparam int UST_FIFO_CNT_W = 3;
   localparam logic [7:0] UST_BIT_CYCLES = 8'h10; // clocks per serial bit
   localparam logic [3:0] UST_FRAME_BITS = 4'h9; // start, eight data, stop, minus one
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [0:0] {
      UST_TX_IDLE = 1'b0,
      UST_TX_SHIFT = 1'b1
   } ust_tx_state_t;
   typedef struct packed {
      ust_tx_state_t state;
      logic [9:0] shift;
      logic [3:0] bits;
      logic [7:0] baud;
      logic txd;
      logic cts;
      logic tx_idle;
      logic par_err;
      logic frm_err;
      logic ovr;
      logic [4:0] int_stat;
      logic [4:0] int_en;
      logic irq;
      logic [15:0] rdata;
   } ust_state_t;
   localparam ust_state_t UST_STATE_RST = '{
      state: UST_TX_IDLE, shift: 10'h3FF, bits: 4'h0, baud: 8'h00,
      txd: 1'b1, cts: 1'b0, tx_idle: 1'b1, par_err: 1'b0, frm_err: 1'b0,
      ovr: 1'b0, int_stat: 5'h00, int_en: 5'h00, irq: 1'b0, rdata: 16'h0000
   };
endpackage

/* File: ust_fifo.sv */
`timescale 1ns/1ps
module ust_fifo (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // filling side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [7:0] in_data_i,
   // draining side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [7:0] out_data_o
);
   import ust_pkg::*;
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [UST_FIFO_DEPTH-1:0][7:0] mem;
      logic [1:0] rd;
      logic [1:0] wr;
      logic [UST_FIFO_CNT_W-1:0] cnt;
   } ust_fifo_t;
   ust_fifo_t f_reg; // registered state
   ust_fifo_t f_next; // next state
   logic push; // accepted write
   logic pop; // accepted read

   // honest full and empty from the count
   assign in_ready_o = (f_reg.cnt != UST_FIFO_CNT_W'(UST_FIFO_DEPTH));
   assign out_valid_o = (f_reg.cnt != '0);
   assign out_data_o = f_reg.mem[f_reg.rd];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // pointer and count update, oldest byte leaves first
   always_comb begin
      f_next = f_reg;
      if (push) begin
         f_next.mem[f_reg.wr] = in_data_i;
         f_next.wr = f_reg.wr + 2'h1;
      end
      if (pop) begin
         f_next.rd = f_reg.rd + 2'h1;
      end
      case ({push, pop})
         2'b10: f_next.cnt = f_reg.cnt + 3'h1;
         2'b01: f_next.cnt = f_reg.cnt - 3'h1;
         default: f_next.cnt = f_reg.cnt;
      endcase
   end

   // registers
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         f_reg <= '0;
      end else begin
         f_reg <= f_next;
      end
   end
endmodule // ust_fifo

/* File: ust_remote.sv */
`timescale 1ns/1ps
module ust_remote (
   // clock
   input wire logic clk_i,
   // serial line from the block
   input wire logic txd_i,
   // hold-off request from the bench
   input wire logic hold_i,
   // handshake back to the block
   output logic cts_n_o,
   // decoded traffic
   output logic [7:0] last_o,
   output logic [7:0] count_o
);
   logic [7:0] shift; // bits of the frame being decoded
   int b; // bit index
   // ----------------------------------------
   // handshake and frame decoder
   // ----------------------------------------
   // pin low while the bench lets characters through
   assign cts_n_o = hold_i;
   initial begin
      last_o = 8'h00;
      count_o = 8'h00;
   end
   // one 8N1 frame per falling edge, sampled mid-bit, lsb first
   always begin
      @(negedge txd_i);
      repeat (8) @(posedge clk_i);
      for (b = 0; b < 8; b++) begin
         repeat (16) @(posedge clk_i);
         shift[b] = txd_i;
      end
      repeat (16) @(posedge clk_i);
      // only frames with a good stop bit count
      if (txd_i === 1'b1) begin
         last_o = shift;
         count_o = count_o + 8'h01;
      end
   end
endmodule // ust_remote

/* File: uart_status_flags_test.sv */
`timescale 1ns/1ps
module uart_status_flags_test;
   import ust_pkg::*;
   // ----------------------------------------
   // signals and counters
   // ----------------------------------------
   logic clk_i, resetn_i, wr_i, rd_i, rxv, par, frm, hold, txd, cts_n, irq;
   logic [15:0] addr, wdata, rdata, rd_val;
   logic [7:0] rxd, last, count;
   int miscompares = 0;
   int comparisons = 0;
   int cyc = 0;
   int i;
   typedef struct {logic [7:0] d; logic p; logic f; logic [15:0] s;} ust_row_t;
   // received byte, its error bits, status expected after it
   ust_row_t rows [4] = '{'{8'h11, 1'b0, 1'b0, 16'h0047}, '{8'h22, 1'b1, 1'b0, 16'h0067},
      '{8'h33, 1'b0, 1'b1, 16'h0057}, '{8'hFF, 1'b1, 1'b1, 16'h0077}};
   ust_status dut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .rx_char_valid_i(rxv), .rx_char_i(rxd),
      .rx_par_err_i(par), .rx_frm_err_i(frm), .cts_n_i(cts_n), .txd_o(txd), .irq_o(irq));
   ust_remote far (.clk_i(clk_i), .txd_i(txd), .hold_i(hold), .cts_n_o(cts_n),
      .last_o(last), .count_o(count));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic finish_test;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // one-cycle write strobe
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   // read, data taken in the cycle after the strobe
   task automatic rdchk(input logic [15:0] a, input logic [15:0] exp);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 rd_val = rdata;
      chk(rd_val, exp);
   endtask
   // one received character strobe
   task automatic rx(input logic [7:0] d, input logic p, input logic f);
      @(posedge clk_i);
      rxv <= 1'b1;
      rxd <= d;
      par <= p;
      frm <= f;
      @(posedge clk_i);
      rxv <= 1'b0;
   endtask
   // wait n edges, then let updates land
   task automatic waitn(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // bounded wait for the far side to count n frames
   task automatic wait_count(input logic [7:0] n);
      for (int k = 0; k < 400 && count !== n; k++) @(posedge clk_i);
   endtask
   // ----------------------------------------
   // clock and hang guard
   // ----------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         finish_test();
      end
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      {resetn_i, wr_i, rd_i, rxv, par, frm, hold} = 7'h00;
      addr = 16'h0000;
      wdata = 16'h0000;
      rxd = 8'h00;
      repeat (8) @(posedge clk_i);
      resetn_i <= 1'b1;
      waitn(1);
      chk({14'h0000, txd, irq}, 16'h0002);
      rdchk(UST_OFF_STATUS, 16'h0045);
      // table of received characters and their flags
      for (i = 0; i < 4; i++) begin
         rx(rows[i].d, rows[i].p, rows[i].f);
         rdchk(UST_OFF_STATUS, rows[i].s);
         rdchk(UST_OFF_DATA, {8'h00, rows[i].d});
         rdchk(UST_OFF_STATUS, 16'h0045);
      end
      // five characters into a four-deep queue
      for (i = 0; i < 5; i++) rx(8'h80 + 8'(i), 1'b0, 1'b0);
      rdchk(UST_OFF_STATUS, 16'h004F);
      for (i = 0; i < 4; i++) rdchk(UST_OFF_DATA, 16'h0080 + 16'(i));
      rdchk(UST_OFF_DATA, 16'h0000);
      rdchk(UST_OFF_STATUS, 16'h0045);
      rdchk(16'h4400, 16'h0000);
      // interrupt raised, cleared, then masked
      rdchk(UST_OFF_INT_STAT, 16'h000F);
      wr(UST_OFF_INT_EN, 16'h0001);
      rx(8'h5E, 1'b0, 1'b0);
      waitn(2);
      chk({15'h0000, irq}, 16'h0001);
      wr(UST_OFF_INT_CLR, 16'h001F);
      waitn(2);
      chk({15'h0000, irq}, 16'h0000);
      wr(UST_OFF_INT_EN, 16'h0000);
      rx(8'h5F, 1'b0, 1'b0);
      waitn(2);
      chk({15'h0000, irq}, 16'h0000);
      rdchk(UST_OFF_INT_STAT, 16'h0001);
      wr(UST_OFF_INT_CLR, 16'h001F);
      rdchk(UST_OFF_DATA, 16'h005E);
      rdchk(UST_OFF_DATA, 16'h005F);
      // hold-off arrives mid-frame, queue fills and refuses
      wr(UST_OFF_DATA, 16'h003C);
      waitn(40);
      rdchk(UST_OFF_STATUS, 16'h0005);
      @(posedge clk_i);
      hold <= 1'b1;
      for (i = 0; i < 5; i++) wr(UST_OFF_DATA, 16'h0051 + 16'(i));
      waitn(400);
      chk({count, last}, 16'h013C);
      rdchk(UST_OFF_STATUS, 16'h0000);
      chk({15'h0000, txd}, 16'h0001);
      @(posedge clk_i);
      hold <= 1'b0;
      for (i = 0; i < 4; i++) begin
         wait_count(8'h02 + 8'(i));
         chk({8'h00, last}, 16'h0051 + 16'(i));
      end
      waitn(300);
      chk({8'h00, count}, 16'h0005);
      rdchk(UST_OFF_STATUS, 16'h0045);
      rdchk(UST_OFF_INT_STAT, 16'h0010);
      finish_test();
   end
endmodule // uart_status_flags_test
